// [clkgen_ratio_pkg.sv]
// Package: register map, field layout and reset values of the ratio gens
// Notes on behaviour
// - Gen2 divisor is 9-bit unsigned in bits 8:0, resets to nine, rest reserved.
// - Gen2 multiplier is 9-bit unsigned in bits 8:0, resets to one, rest reserved.
// - Gen3 divisor fills all 16 bits, unsigned, resets to zero.
// - Gen3 multiplier fills all 16 bits, unsigned, resets to zero.
// - Select bit clear: gen3 runs from the PLL clock at multiplier/divisor.
// - Select bit set: gen3 runs at external rate times multiplier over 1024.
// - Pin code bits 3:0 pick the external input; ignored in PLL mode.
// - Code 1110 picks the S/PDIF rate signal; register resets to 0x000E.
// - External reference may come from a multipurpose pin or S/PDIF.
// - Source register bits 15:5 are reserved, read zero, do nothing.
// - Codes 0000 to 0110 pick multipurpose pins 0 to 6.
`default_nettype none

package clkgen_ratio_pkg;

	// ------------------------------------------------------------------
	// Register indices; byte address is four times the index
	// ------------------------------------------------------------------
	localparam logic [15:0] IDX_GEN2_DEN   = 16'hF022;
	localparam logic [15:0] IDX_GEN2_MUL   = 16'hF023;
	localparam logic [15:0] IDX_GEN3_DEN   = 16'hF024;
	localparam logic [15:0] IDX_GEN3_MUL   = 16'hF025;
	localparam logic [15:0] IDX_GEN3_SRC   = 16'hF026;
	localparam logic [15:0] IDX_STATUS     = 16'hF027;

	// ------------------------------------------------------------------
	// Field layout
	// ------------------------------------------------------------------
	localparam int          GEN2_W         = 9;
	localparam int          GEN3_W         = 16;
	localparam int          SRC_EXT_BIT    = 4;
	localparam int          PIN_CODE_W     = 4;
	localparam int          MP_COUNT       = 7;
	localparam int          DIV_W          = 17;

	// ------------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------------
	localparam logic [8:0]  GEN2_DEN_RST   = 9'h009;
	localparam logic [8:0]  GEN2_MUL_RST   = 9'h001;
	localparam logic [15:0] GEN3_DEN_RST   = 16'h0000;
	localparam logic [15:0] GEN3_MUL_RST   = 16'h0000;
	localparam logic [3:0]  PIN_CODE_RST   = 4'hE;
	localparam logic        SRC_EXT_RST    = 1'b0;

	// ------------------------------------------------------------------
	// Reference codes and fixed external divisor
	// ------------------------------------------------------------------
	localparam logic [3:0]  CODE_SPDIF     = 4'hE;
	localparam logic [3:0]  CODE_MP_LAST   = 4'h6;
	localparam logic [16:0] EXT_DIVISOR    = 17'h00400;

endpackage

`default_nettype wire

// [frac_rate_gen.sv]
// Fractional rate generator: one enable pulse per divisor/multiplier events
`timescale 1ns/1ps
`default_nettype none

module frac_rate_gen
	import clkgen_ratio_pkg::*;
(
	input  wire logic              clk,
	input  wire logic              rst,
	input  wire logic              ref_tick,
	input  wire logic [15:0]       mult,
	input  wire logic [DIV_W-1:0]  div,
	output logic                   tick_o
);

	logic [DIV_W-1:0] acc_r;
	logic [DIV_W:0]   sum;
	logic [DIV_W:0]   rem;

	// Phase sum; one guard bit so no carry is lost
	assign sum = {1'b0, acc_r} + {{(DIV_W-15){1'b0}}, mult};
	assign rem = sum - {1'b0, div};

	// Accumulate per reference event; ratios above one saturate at one
	// pulse per event, zero divisor holds the phase and stays silent
	always_ff @(posedge clk) begin
		if (rst) begin
			acc_r  <= '0;
			tick_o <= 1'b0;
		end else begin
			tick_o <= 1'b0;
			if (ref_tick && div != '0) begin
				if (sum >= {1'b0, div}) begin
					tick_o <= 1'b1;
					if (rem >= {1'b0, div}) begin
						acc_r <= '0;
					end else begin
						acc_r <= rem[DIV_W-1:0];
					end
				end else begin
					acc_r <= sum[DIV_W-1:0];
				end
			end
		end
	end

	// Silent without a reference event or with a zero divisor
	quiet_gen_a: assert property (@(posedge clk) disable iff (rst)
		(!ref_tick || div == '0) |=> !tick_o)
		else $error("rate pulse without event or with zero divisor");

endmodule // frac_rate_gen

`default_nettype wire

// [audio_clock_ratio_generators.sv]
// Top: gen2/gen3 ratio registers, Avalon-MM slave and reference routing
//
// Design decision made here: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module audio_clock_ratio_generators
	import clkgen_ratio_pkg::*;
(
	input  wire logic                CLK,
	input  wire logic                RST,
	input  wire logic [17:0]         ADDRESS,
	input  wire logic                READ,
	input  wire logic                WRITE,
	input  wire logic [31:0]         WRITEDATA,
	input  wire logic [3:0]          BYTEENABLE,
	output logic      [31:0]         READDATA,
	output logic                     WAITREQUEST,
	input  wire logic [MP_COUNT-1:0] MULTIPURPOSE_PIN,
	input  wire logic                SPDIF_RATE,
	output logic                     GEN2_TICK,
	output logic                     GEN3_TICK,
	output logic                     GEN3_EXT_ACTIVE
);

	// ------------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------------
	logic [GEN2_W-1:0]     second_gen_divisor_r;
	logic [GEN2_W-1:0]     second_gen_multiplier_r;
	logic [GEN3_W-1:0]     third_gen_divisor_r;
	logic [GEN3_W-1:0]     third_gen_multiplier_r;
	logic                  third_gen_ref_select_r;
	logic [PIN_CODE_W-1:0] third_gen_ref_input_r;
	logic                  ack_r;
	logic                  wait_r;
	logic [31:0]           readdata_r;
	logic                  ref_prev_r;
	logic                  ext_active_r;
	logic                  req;
	logic                  wr_go;
	logic [15:0]           index;
	logic                  aligned;
	logic [31:0]           rd_nxt;
	logic                  ref_level;
	logic                  ref_valid;
	logic                  ref_rise;
	logic                  gen3_ref_tick;
	logic [DIV_W-1:0]      gen3_div;
	logic [15:0]           wr_word;
	logic [15:0]           gen2_den_word;
	logic [15:0]           gen2_mul_word;

	// Lane merge for a 16-bit register living in byte lanes 0 and 1
	function automatic logic [15:0] merge16(input logic [15:0] old,
		input logic [31:0] data, input logic [3:0] be);
		logic [15:0] res;
		res = old;
		if (be[0]) begin
			res[7:0] = data[7:0];
		end
		if (be[1]) begin
			res[15:8] = data[15:8];
		end
		return res;
	endfunction

	// ------------------------------------------------------------------
	// Avalon-MM handshake
	// ------------------------------------------------------------------

	// Decode; a misaligned byte address maps to nothing
	assign req     = READ || WRITE;
	assign index   = ADDRESS[17:2];
	assign aligned = ADDRESS[1:0] == 2'b00;
	assign wr_go   = WRITE && ack_r && aligned;

	// One wait cycle per request; the second edge completes it. Keeping a
	// fixed wait lets read data be registered, at one cycle of latency.
	always_ff @(posedge CLK) begin
		if (RST) begin
			ack_r <= 1'b0;
		end else begin
			ack_r <= req && !ack_r;
		end
	end

	// Wait flag kept in its own flop so the pin has no gate behind it;
	// it always equals the inverse of ack_r
	always_ff @(posedge CLK) begin
		if (RST) begin
			wait_r <= 1'b1;
		end else begin
			wait_r <= !(req && !ack_r);
		end
	end

	// Read mux; unmapped indices and reserved bits answer zero
	always_comb begin
		rd_nxt = 32'h0000_0000;
		if (aligned) begin
			case (index)
				IDX_GEN2_DEN: begin
					rd_nxt[GEN2_W-1:0] = second_gen_divisor_r;
				end
				IDX_GEN2_MUL: begin
					rd_nxt[GEN2_W-1:0] = second_gen_multiplier_r;
				end
				IDX_GEN3_DEN: begin
					rd_nxt[GEN3_W-1:0] = third_gen_divisor_r;
				end
				IDX_GEN3_MUL: begin
					rd_nxt[GEN3_W-1:0] = third_gen_multiplier_r;
				end
				IDX_GEN3_SRC: begin
					rd_nxt[SRC_EXT_BIT] = third_gen_ref_select_r;
					rd_nxt[PIN_CODE_W-1:0] = third_gen_ref_input_r;
				end
				IDX_STATUS: begin
					rd_nxt[0] = ext_active_r;
					rd_nxt[1] = ref_valid;
					rd_nxt[2] = ref_level;
				end
				default: begin
					rd_nxt = 32'h0000_0000;
				end
			endcase
		end
	end

	// Read data captured as the wait drops, so it stands stable
	always_ff @(posedge CLK) begin
		if (RST) begin
			readdata_r <= 32'h0000_0000;
		end else if (READ && !ack_r) begin
			readdata_r <= rd_nxt;
		end
	end

	assign READDATA    = readdata_r;
	assign WAITREQUEST = wait_r;

	// ------------------------------------------------------------------
	// Ratio registers
	// ------------------------------------------------------------------

	assign wr_word = merge16(16'h0000, WRITEDATA, BYTEENABLE);

	// Lane merges for the 9-bit registers; upper bits are dropped below
	assign gen2_den_word = merge16({7'h00, second_gen_divisor_r},
		WRITEDATA, BYTEENABLE);
	assign gen2_mul_word = merge16({7'h00, second_gen_multiplier_r},
		WRITEDATA, BYTEENABLE);

	// Second generator divisor and multiplier, 9 bits each
	always_ff @(posedge CLK) begin
		if (RST) begin
			second_gen_divisor_r    <= GEN2_DEN_RST;
			second_gen_multiplier_r <= GEN2_MUL_RST;
		end else if (wr_go && index == IDX_GEN2_DEN) begin
			second_gen_divisor_r <= gen2_den_word[GEN2_W-1:0];
		end else if (wr_go && index == IDX_GEN2_MUL) begin
			second_gen_multiplier_r <= gen2_mul_word[GEN2_W-1:0];
		end
	end

	// Third generator divisor and multiplier, full 16 bits
	always_ff @(posedge CLK) begin
		if (RST) begin
			third_gen_divisor_r    <= GEN3_DEN_RST;
			third_gen_multiplier_r <= GEN3_MUL_RST;
		end else if (wr_go && index == IDX_GEN3_DEN) begin
			third_gen_divisor_r <= merge16(third_gen_divisor_r,
				WRITEDATA, BYTEENABLE);
		end else if (wr_go && index == IDX_GEN3_MUL) begin
			third_gen_multiplier_r <= merge16(third_gen_multiplier_r,
				WRITEDATA, BYTEENABLE);
		end
	end

	// Source register; reserved bits 15:5 are not stored
	always_ff @(posedge CLK) begin
		if (RST) begin
			third_gen_ref_select_r <= SRC_EXT_RST;
			third_gen_ref_input_r  <= PIN_CODE_RST;
		end else if (wr_go && index == IDX_GEN3_SRC && BYTEENABLE[0]) begin
			third_gen_ref_select_r <= wr_word[SRC_EXT_BIT];
			third_gen_ref_input_r  <= wr_word[PIN_CODE_W-1:0];
		end
	end

	// ------------------------------------------------------------------
	// Reference routing for the third generator
	// ------------------------------------------------------------------

	// Pin code picks a multipurpose pin or the S/PDIF rate signal;
	// undefined codes give no reference, so in external mode the generator stays quiet
	always_comb begin
		ref_level = 1'b0;
		ref_valid = 1'b0;
		if (third_gen_ref_input_r == CODE_SPDIF) begin
			ref_level = SPDIF_RATE;
			ref_valid = 1'b1;
		end else if (third_gen_ref_input_r <= CODE_MP_LAST) begin
			ref_level = MULTIPURPOSE_PIN[third_gen_ref_input_r[2:0]];
			ref_valid = 1'b1;
		end
	end

	// Rising edge marks one reference period; any duty cycle gives one
	// edge per period, so long as each level lasts at least one clock
	always_ff @(posedge CLK) begin
		if (RST) begin
			ref_prev_r <= 1'b0;
		end else begin
			ref_prev_r <= ref_level;
		end
	end

	assign ref_rise = ref_level && !ref_prev_r;

	// PLL mode counts every system clock and divides by the register;
	// external mode counts reference edges and divides by 1024
	assign gen3_ref_tick = third_gen_ref_select_r ?
		(ref_rise && ref_valid) : 1'b1;
	assign gen3_div = third_gen_ref_select_r ? EXT_DIVISOR :
		{1'b0, third_gen_divisor_r};

	// Mode flag for the outside, registered
	always_ff @(posedge CLK) begin
		if (RST) begin
			ext_active_r <= 1'b0;
		end else begin
			ext_active_r <= third_gen_ref_select_r;
		end
	end

	assign GEN3_EXT_ACTIVE = ext_active_r;

	// ------------------------------------------------------------------
	// Rate generators
	// ------------------------------------------------------------------

	// Second generator always runs from the system clock
	frac_rate_gen u_gen2 (
		.clk      (CLK),
		.rst      (RST),
		.ref_tick (1'b1),
		.mult     ({7'h00, second_gen_multiplier_r}),
		.div      ({8'h00, second_gen_divisor_r}),
		.tick_o   (GEN2_TICK)
	);

	// Third generator; a zero divisor in PLL mode leaves it silent
	frac_rate_gen u_gen3 (
		.clk      (CLK),
		.rst      (RST),
		.ref_tick (gen3_ref_tick),
		.mult     (third_gen_multiplier_r),
		.div      (gen3_div),
		.tick_o   (GEN3_TICK)
	);

	// ------------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------------

	sequence wr_to(logic [15:0] idx);
		WRITE && !WAITREQUEST && aligned && index == idx
			&& BYTEENABLE[1:0] == 2'b11;
	endsequence

	sequence rd_of(logic [15:0] idx);
		READ && WAITREQUEST && aligned && index == idx;
	endsequence

	gen2_reset_a: assert property (@(posedge CLK)
		RST |=> second_gen_divisor_r == 9'h009
			&& second_gen_multiplier_r == 9'h001)
		else $error("gen2 reset values wrong");

	gen2_div_wr_a: assert property (@(posedge CLK) disable iff (RST)
		wr_to(IDX_GEN2_DEN) |=>
			second_gen_divisor_r == $past(WRITEDATA[8:0]))
		else $error("gen2 divisor write lost");

	gen2_mul_wr_a: assert property (@(posedge CLK) disable iff (RST)
		wr_to(IDX_GEN2_MUL) |=>
			second_gen_multiplier_r == $past(WRITEDATA[8:0]))
		else $error("gen2 multiplier write lost");

	gen3_den_wr_a: assert property (@(posedge CLK) disable iff (RST)
		wr_to(IDX_GEN3_DEN) |=>
			third_gen_divisor_r == $past(WRITEDATA[15:0]))
		else $error("gen3 divisor write lost");

	gen3_reg_wr_a: assert property (@(posedge CLK) disable iff (RST)
		wr_to(IDX_GEN3_MUL) |=>
			third_gen_multiplier_r == $past(WRITEDATA[15:0]))
		else $error("gen3 multiplier write lost");

	gen3_div_rd_a: assert property (@(posedge CLK) disable iff (RST)
		rd_of(IDX_GEN3_DEN) |=> !WAITREQUEST
			&& READDATA == {16'h0000, third_gen_divisor_r})
		else $error("gen3 divisor read wrong");

	src_reserved_a: assert property (@(posedge CLK) disable iff (RST)
		rd_of(IDX_GEN3_SRC) |=> READDATA[31:5] == 27'h0000000)
		else $error("source reserved bits not zero");

	src_reset_a: assert property (@(posedge CLK)
		RST |=> third_gen_ref_input_r == 4'hE
			&& !third_gen_ref_select_r)
		else $error("source register reset wrong");

	spdif_route_a: assert property (@(posedge CLK) disable iff (RST)
		third_gen_ref_input_r == 4'hE |-> ref_level == SPDIF_RATE)
		else $error("S/PDIF rate not routed");

	pin_route_a: assert property (@(posedge CLK) disable iff (RST)
		third_gen_ref_input_r <= 4'h6 |->
			ref_level == MULTIPURPOSE_PIN[third_gen_ref_input_r[2:0]])
		else $error("multipurpose pin not routed");

	pll_mode_a: assert property (@(posedge CLK) disable iff (RST)
		!third_gen_ref_select_r |-> gen3_ref_tick
			&& gen3_div == {1'b0, third_gen_divisor_r})
		else $error("PLL mode reference wrong");

	ext_mode_a: assert property (@(posedge CLK) disable iff (RST)
		third_gen_ref_select_r |-> gen3_div == 17'h00400
			&& (gen3_ref_tick == (ref_rise && ref_valid)))
		else $error("external mode divisor or tick wrong");

	one_wait_a: assert property (@(posedge CLK) disable iff (RST)
		(req && WAITREQUEST) |=> !WAITREQUEST ##1 WAITREQUEST)
		else $error("answer not one cycle after request");

	src_write_a: assert property (@(posedge CLK) disable iff (RST)
		wr_to(IDX_GEN3_SRC) |=>
			third_gen_ref_input_r == $past(WRITEDATA[3:0])
			&& third_gen_ref_select_r == $past(WRITEDATA[4]))
		else $error("source register write lost");

	bad_code_a: assert property (@(posedge CLK) disable iff (RST)
		(third_gen_ref_select_r && !ref_valid) |-> !gen3_ref_tick)
		else $error("reference event from an undefined pin code");

	ext_flag_a: assert property (@(posedge CLK) disable iff (RST)
		third_gen_ref_select_r |=> GEN3_EXT_ACTIVE)
		else $error("external mode flag not raised");

endmodule // audio_clock_ratio_generators

`default_nettype wire

// [audio_clock_ratio_generators_test.sv]
// Self-checking bench for the gen2/gen3 ratio registers and tick outputs
`timescale 1ns/1ps
`default_nettype none

module audio_clock_ratio_generators_test;
	import clkgen_ratio_pkg::*;

	// ------------------------------------------------------------------
	// Stimulus and observation signals
	// ------------------------------------------------------------------
	logic        clk;
	logic        rst;
	logic [17:0] address;
	logic        read;
	logic        write;
	logic [31:0] writedata;
	logic [3:0]  byteenable;
	logic [31:0] readdata;
	logic        waitrequest;
	logic [7:0]  pins;
	logic        gen2_tick;
	logic        gen3_tick;
	logic        gen3_ext_active;
	int          errors;
	int          n_tests;
	int          c2;
	int          c3;

	audio_clock_ratio_generators dut (
		.CLK              (clk),
		.RST              (rst),
		.ADDRESS          (address),
		.READ             (read),
		.WRITE            (write),
		.WRITEDATA        (writedata),
		.BYTEENABLE       (byteenable),
		.READDATA         (readdata),
		.WAITREQUEST      (waitrequest),
		.MULTIPURPOSE_PIN (pins[6:0]),
		.SPDIF_RATE       (pins[7]),
		.GEN2_TICK        (gen2_tick),
		.GEN3_TICK        (gen3_tick),
		.GEN3_EXT_ACTIVE  (gen3_ext_active)
	);

	// Clock at 50 MHz
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	// Tick counters; windows are judged by differences of these
	initial begin
		c2 = 0;
		c3 = 0;
	end
	always @(posedge clk) begin
		if (gen2_tick === 1'b1) c2 <= c2 + 1;
		if (gen3_tick === 1'b1) c3 <= c3 + 1;
	end

	// ------------------------------------------------------------------
	// Shared tasks
	// ------------------------------------------------------------------
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			errors++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic stop_test();
		$display("checks=%0d mismatches=%0d", n_tests, errors);
		if (errors == 0 && n_tests > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// One Avalon transfer; held until waitrequest is sampled low
	task automatic bus(input logic wr, input logic [15:0] idx,
			input logic [31:0] wd, input logic [3:0] be,
			output logic [31:0] rd);
		int n;
		@(posedge clk);
		address <= {idx, 2'b00};
		write <= wr;
		read <= !wr;
		writedata <= wd;
		byteenable <= be;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (waitrequest !== 1'b0 && n < 20);
		check({31'h0, waitrequest}, 32'h0);
		rd = readdata;
		write <= 1'b0;
		read <= 1'b0;
	endtask

	task automatic wr(input logic [15:0] idx, input logic [15:0] d,
			input logic [3:0] be = 4'h3);
		logic [31:0] x;
		bus(1'b1, idx, {16'h0, d}, be, x);
	endtask

	task automatic rd(input logic [15:0] idx, output logic [31:0] d);
		bus(1'b0, idx, 32'h0, 4'hF, d);
	endtask

	// Square wave on the masked inputs, 4 cycles high and 4 low per period
	task automatic run_pins(input logic [7:0] mask, input int periods);
		repeat (periods) begin
			repeat (4) @(posedge clk);
			pins <= mask;
			repeat (4) @(posedge clk);
			pins <= 8'h00;
		end
		repeat (6) @(posedge clk);
	endtask

	// ------------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------------
	task automatic t_reset_values();
		logic [31:0] d;
		rd(IDX_GEN2_DEN, d); check(d, 32'h0009);
		rd(IDX_GEN2_MUL, d); check(d, 32'h0001);
		rd(IDX_GEN3_DEN, d); check(d, 32'h0000);
		rd(IDX_GEN3_MUL, d); check(d, 32'h0000);
		rd(IDX_GEN3_SRC, d); check(d, 32'h000E);
		check({31'h0, gen3_ext_active}, 32'h0);
		$display("test reset_values done");
	endtask

	// Gen2 at reset ratio one over nine: 10 ticks in any 90 cycles
	task automatic t_gen2_rate();
		int s;
		repeat (20) @(posedge clk);
		s = c2;
		repeat (90) @(posedge clk);
		check(c2 - s, 32'd10);
		wr(IDX_GEN2_MUL, 16'h0002);
		wr(IDX_GEN2_DEN, 16'h0006);
		repeat (20) @(posedge clk);
		s = c2;
		repeat (90) @(posedge clk);
		check(c2 - s, 32'd30);
		$display("test gen2_rate done");
	endtask

	// Reserved bits are not kept; byte lanes honoured; unmapped reads zero
	task automatic t_field_widths();
		logic [31:0] d;
		wr(IDX_GEN2_DEN, 16'hFFFF);
		rd(IDX_GEN2_DEN, d); check(d, 32'h01FF);
		wr(IDX_GEN2_MUL, 16'hFFFF);
		rd(IDX_GEN2_MUL, d); check(d, 32'h01FF);
		wr(IDX_GEN3_DEN, 16'hFFFF);
		rd(IDX_GEN3_DEN, d); check(d, 32'hFFFF);
		wr(IDX_GEN3_MUL, 16'hFFFF);
		wr(IDX_GEN3_MUL, 16'hABCD, 4'h2);
		rd(IDX_GEN3_MUL, d); check(d, 32'hABFF);
		wr(IDX_GEN3_SRC, 16'hFFE3);
		rd(IDX_GEN3_SRC, d); check(d, 32'h0003);
		rd(16'hF030, d); check(d, 32'h0000);
		$display("test field_widths done");
	endtask

	// PLL mode: one tick per 4 cycles, pin code and pin activity ignored
	task automatic t_pll_mode();
		int s;
		wr(IDX_GEN3_MUL, 16'h0001);
		wr(IDX_GEN3_DEN, 16'h0004);
		wr(IDX_GEN3_SRC, 16'h0003);
		repeat (10) @(posedge clk);
		check({31'h0, gen3_ext_active}, 32'h0);
		s = c3;
		repeat (80) @(posedge clk);
		check(c3 - s, 32'd20);
		s = c3;
		run_pins(8'hFF, 5);
		repeat (2) @(posedge clk);
		check(c3 - s, 32'd12);
		wr(IDX_GEN3_DEN, 16'h0000);
		repeat (10) @(posedge clk);
		s = c3;
		repeat (40) @(posedge clk);
		check(c3 - s, 32'd0);
		$display("test pll_mode done");
	endtask

	// External mode: code picks input, rate is edges times N over 1024, at most one tick per edge
	task automatic ext_case(input logic [3:0] code, input logic [7:0] sel,
			input logic [15:0] mul, input int exp);
		int s;
		logic [31:0] d;
		logic v;
		wr(IDX_GEN3_MUL, mul);
		wr(IDX_GEN3_SRC, {12'h001, code});
		repeat (4) @(posedge clk);
		check({31'h0, gen3_ext_active}, 32'h1);
		v = (code <= CODE_MP_LAST) || (code == CODE_SPDIF);
		rd(IDX_STATUS, d);
		check(d, {30'h0, v, 1'b1});
		s = c3;
		run_pins(sel, 10);
		check(c3 - s, exp);
		s = c3;
		run_pins(~sel, 10);
		check(c3 - s, 32'd0);
	endtask

	task automatic t_ext_mode();
		wr(IDX_GEN3_DEN, 16'h0000);
		for (int k = 0; k < 7; k++)
			ext_case(k[3:0], 8'h01 << k, 16'h0400, 10);
		ext_case(CODE_SPDIF, 8'h80, 16'h0400, 10);
		ext_case(4'h7, 8'hFF, 16'h0400, 0);
		ext_case(CODE_SPDIF, 8'h80, 16'h0800, 10);
		ext_case(4'h2, 8'h04, 16'h0000, 0);
		$display("test ext_mode done");
	endtask

	// ------------------------------------------------------------------
	// Main sequence and watchdog
	// ------------------------------------------------------------------
	initial begin
		errors = 0;
		n_tests = 0;
		rst = 1'b1;
		address = 18'h0;
		read = 1'b0;
		write = 1'b0;
		writedata = 32'h0;
		byteenable = 4'h0;
		pins = 8'h00;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		t_reset_values();
		t_gen2_rate();
		t_field_widths();
		t_pll_mode();
		t_ext_mode();
		stop_test();
	end

	// Whole run is a few thousand cycles; this leaves ample margin
	initial begin
		#1000000;
		errors++;
		stop_test();
	end

endmodule // audio_clock_ratio_generators_test

`default_nettype wire
